// file: src/ios_indicator_select.sv
// Purpose: selects which network events drive the third indicator pin
// Assumes: event inputs come from other clock domains; AHB-Lite slave
// Notes: one 16-bit register in the low half of one word, zero wait states
// What this block does
// - the pin shows the OR of every event whose enable bit is set.
// - after reset only transmit activity is enabled, with stretching on.
// - bit 15 reads back the combined state before stretching.
// - reserved bits read as zero and software writes them as zero.
// - with the match qualifier set only address-matched receives count.
// - bit 4 adds transmit activity to the OR when set.
// - bit 3 asserts the pin while receive polarity is correct.
// - bit 7 stretches each assertion, else the raw state is driven.
// - bit 2 adds receive activity to the OR when set.
// - bit 1 adds the jabber condition to the OR when set.
// - bit 0 adds collision activity to the OR when set.
`timescale 1ns/100ps
`default_nettype none
module ios_indicator_select #(
  parameter int unsigned STRETCH_CYCLES = ios_pkg::STRETCH_CYCLES_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  input wire logic i_tx_activity,
  input wire logic i_rx_activity,
  input wire logic i_rx_addr_match,
  input wire logic i_rx_polarity_ok,
  input wire logic i_jabber,
  input wire logic i_collision,
  output logic o_third_indicator_pin
);
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic tx_s;
  logic rx_s;
  logic am_s;
  logic pol_s;
  logic jab_s;
  logic col_s;
  logic [15:0] cfg_q;
  logic raw_d;
  logic raw_q;
  logic pin_q;
  logic wr_pend_q;
  logic [31:0] rdata_q;
  logic [15:0] cfg_view;
  logic [4:0] contrib;
  logic addr_phase;

  ios_stretch_if s_if ();

  function automatic logic reg_hit(input logic [31:0] addr);
    reg_hit = addr[31:2] == ios_pkg::ISEL_ADDR[31:2];
  endfunction

  // only whole-word writes are honoured; other sizes complete but store nothing
  function automatic logic [15:0] wr_value(input logic [31:0] data);
    wr_value = data[15:0] & ios_pkg::ISEL_WMASK;
  endfunction

  // event sources are asynchronous to the system clock
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {i_collision, i_jabber, i_rx_polarity_ok,
                  i_rx_addr_match, i_rx_activity, i_tx_activity};
      sync2_q <= sync1_q;
    end
  end

  assign tx_s = sync2_q[0];
  assign rx_s = sync2_q[1];
  assign am_s = sync2_q[2];
  assign pol_s = sync2_q[3];
  assign jab_s = sync2_q[4];
  assign col_s = sync2_q[5];

  // per-source contributions, each gated by its enable bit
  assign contrib[0] = cfg_q[ios_pkg::F_COL] && col_s;
  assign contrib[1] = cfg_q[ios_pkg::F_JAB] && jab_s;
  assign contrib[2] = cfg_q[ios_pkg::F_RX] && rx_s &&
                      (!cfg_q[ios_pkg::F_RXQ] || am_s);
  assign contrib[3] = cfg_q[ios_pkg::F_POL] && pol_s;
  assign contrib[4] = cfg_q[ios_pkg::F_TX] && tx_s;
  assign raw_d = |contrib;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      raw_q <= 1'b0;
    end else begin
      raw_q <= raw_d;
    end
  end

  assign s_if.raw = raw_q;
  assign s_if.enable = cfg_q[ios_pkg::F_PSE];

  ios_stretcher #(
    .STRETCH_CYCLES(STRETCH_CYCLES)
  ) u_stretch (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .s_if(s_if)
  );

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= s_if.shaped;
    end
  end

  // bus slave: zero wait states, so hready from this slave is always high
  assign addr_phase = i_hsel && i_hready && i_htrans[1];

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= addr_phase && i_hwrite && reg_hit(i_haddr) &&
                   i_hsize == ios_pkg::HSIZE_WORD;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cfg_q <= ios_pkg::ISEL_RESET;
    end else if (wr_pend_q) begin
      cfg_q <= wr_value(i_hwdata);
    end
  end

  // forward a write still in its data phase so a back-to-back read sees it
  always_comb begin
    cfg_view = wr_pend_q ? wr_value(i_hwdata) : cfg_q;
    cfg_view[ios_pkg::F_RAW] = raw_q;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_phase && !i_hwrite && reg_hit(i_haddr)) begin
      rdata_q <= {16'h0000, cfg_view};
    end else if (addr_phase) begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign o_hrdata = rdata_q;
  assign o_hreadyout = 1'b1;
  assign o_hresp = ios_pkg::HRESP_OKAY;
  assign o_third_indicator_pin = pin_q;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  chk_reset_default: assert property (
    $past(i_rst) |-> cfg_q == ios_pkg::ISEL_RESET && !o_third_indicator_pin)
    else $error("register not at default after reset");

  chk_or_combine: assert property (
    $past(contrib != 5'h00) |-> raw_q ##1 o_third_indicator_pin)
    else $error("enabled event did not reach the pin");

  chk_none_enabled: assert property (
    $past(contrib == 5'h00) |-> !raw_q)
    else $error("raw state high with no enabled event");

  chk_raw_readback: assert property (
    addr_phase && !i_hwrite && reg_hit(i_haddr) |=> o_hrdata[15] == $past(raw_q))
    else $error("bit 15 does not show the raw state");

  chk_reserved_zero: assert property (
    o_hrdata[31:16] == 16'h0000 && o_hrdata[14:8] == 7'h00 && !o_hrdata[6])
    else $error("reserved bits read as nonzero");

  chk_rx_qualify: assert property (
    $past(cfg_q[ios_pkg::F_RXQ] && !am_s && contrib[4:3] == 2'h0 &&
          contrib[1:0] == 2'h0) |-> !raw_q)
    else $error("unmatched receive drove the indicator");

  chk_tx_select: assert property (
    $past(tx_s && contrib[3:0] == 4'h0) |-> raw_q == $past(cfg_q[ios_pkg::F_TX]))
    else $error("transmit enable not honoured");

  chk_pol_select: assert property (
    $past(pol_s && cfg_q[ios_pkg::F_POL]) |-> raw_q)
    else $error("polarity enable not honoured");

  chk_rx_select: assert property (
    $past(rx_s && cfg_q[ios_pkg::F_RX] && !cfg_q[ios_pkg::F_RXQ]) |-> raw_q)
    else $error("receive enable not honoured");

  chk_jab_select: assert property (
    $past(jab_s && cfg_q[ios_pkg::F_JAB]) |-> raw_q)
    else $error("jabber enable not honoured");

  chk_col_select: assert property (
    $past(col_s && cfg_q[ios_pkg::F_COL]) |-> raw_q)
    else $error("collision enable not honoured");

  chk_no_stretch: assert property (
    $past(!cfg_q[ios_pkg::F_PSE]) |-> o_third_indicator_pin == $past(raw_q))
    else $error("pin differs from raw state with stretching off");

  chk_stretch_hold: assert property (
    cfg_q[ios_pkg::F_PSE] && $fell(raw_q) ##1 cfg_q[ios_pkg::F_PSE] [*7]
    |-> o_third_indicator_pin)
    else $error("stretched pulse ended too early");

  chk_stretch_on_raw: assert property (
    cfg_q[ios_pkg::F_PSE] && raw_q |=> o_third_indicator_pin)
    else $error("pin low while raw state high with stretching on");

  chk_pin_follows_low: assert property (
    !cfg_q[ios_pkg::F_PSE] && !raw_q |=> !o_third_indicator_pin)
    else $error("pin high with raw low and stretching off");

  chk_all_disabled: assert property (
    $past(cfg_q[4:0] == 5'h00) |-> !raw_q)
    else $error("raw state high with every source disabled");

  chk_rxq_pass: assert property (
    $past(cfg_q[ios_pkg::F_RX] && cfg_q[ios_pkg::F_RXQ] && rx_s && am_s) |-> raw_q)
    else $error("matched receive did not drive the indicator");

  chk_sync_chain: assert property (
    sync2_q == $past(sync1_q))
    else $error("second sync stage does not follow the first");

  // bus side checks: the slave never stalls and never errors
  chk_ready_high: assert property (
    o_hreadyout)
    else $error("slave inserted a wait state");

  chk_resp_okay: assert property (
    o_hresp == ios_pkg::HRESP_OKAY)
    else $error("slave response not okay");

  chk_write_lands: assert property (
    wr_pend_q |=> cfg_q == ($past(i_hwdata[15:0]) & ios_pkg::ISEL_WMASK))
    else $error("write data not stored masked");

  chk_word_only: assert property (
    addr_phase && i_hsize != ios_pkg::HSIZE_WORD |=> !wr_pend_q)
    else $error("non-word write was accepted");

  chk_cfg_hold: assert property (
    !wr_pend_q |=> $stable(cfg_q))
    else $error("register changed without a write");

  chk_cfg_reserved: assert property (
    cfg_q[15:8] == 8'h00 && !cfg_q[6])
    else $error("reserved register bits were stored");

  chk_other_reads_zero: assert property (
    addr_phase && (i_hwrite || !reg_hit(i_haddr)) |=> o_hrdata == 32'h0000_0000)
    else $error("write or unmapped read returned nonzero data");

  chk_rdata_stands: assert property (
    !addr_phase |=> $stable(o_hrdata))
    else $error("read data changed outside an address phase");

  chk_rd_register: assert property (
    addr_phase && !i_hwrite && reg_hit(i_haddr) && !wr_pend_q
    |=> o_hrdata[14:0] == $past(cfg_q[14:0]))
    else $error("read data differs from the register");

  chk_rd_forward: assert property (
    addr_phase && !i_hwrite && reg_hit(i_haddr) && wr_pend_q
    |=> o_hrdata[7:0] == ($past(i_hwdata[7:0]) & ios_pkg::ISEL_WMASK[7:0]))
    else $error("read after write missed the new value");

  chk_rdata_reset: assert property (
    $past(i_rst) |-> o_hrdata == 32'h0000_0000)
    else $error("read data not cleared by reset");

  cov_stretch_tail: cover property (
    cfg_q[ios_pkg::F_PSE] && !raw_q && o_third_indicator_pin);
  cov_reg_write: cover property (wr_pend_q);
  cov_qualified_rx: cover property (cfg_q[ios_pkg::F_RXQ] && contrib[2]);
  cov_unmapped_read: cover property (addr_phase && !i_hwrite && !reg_hit(i_haddr));
  // a write that clears stretching while stretching is still on, tail running or not
  cov_stretch_cut: cover property (wr_pend_q && cfg_q[ios_pkg::F_PSE] && !i_hwdata[7]);
endmodule // ios_indicator_select
`default_nettype wire

// file: src/ios_pkg.sv
// Purpose: shared constants for the third indicator output select block
// Assumes: one 20 MHz system clock, AHB-Lite register access
// Notes: all register fields and bus encodings live here
package ios_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam logic [31:0] ISEL_ADDR = 32'h0000_0000;
  localparam int unsigned F_COL = 0;
  localparam int unsigned F_JAB = 1;
  localparam int unsigned F_RX = 2;
  localparam int unsigned F_POL = 3;
  localparam int unsigned F_TX = 4;
  localparam int unsigned F_RXQ = 5;
  localparam int unsigned F_PSE = 7;
  localparam int unsigned F_RAW = 15;
  localparam logic [15:0] ISEL_RESET = 16'h0090;
  localparam logic [15:0] ISEL_WMASK = 16'h00BF;
  localparam int unsigned STRETCH_CYCLES_DEF = 2000;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
endpackage

// file: src/ios_stretch_if.sv
// Purpose: carries the raw indicator state to the pulse stretcher and back
// Assumes: both ends on i_sys_clk
// Notes: shaped is already the final pin value before the output flop
`timescale 1ns/100ps
`default_nettype none
interface ios_stretch_if;
  logic raw;
  logic enable;
  logic shaped;
  modport ctrl (output raw, output enable, input shaped);
  modport strt (input raw, input enable, output shaped);
endinterface // ios_stretch_if
`default_nettype wire

// file: src/ios_stretcher.sv
// Purpose: lengthens each indicator assertion by a fixed number of cycles
// Assumes: raw is a registered level on i_sys_clk
// Notes: with stretching off the raw level passes straight through
`timescale 1ns/100ps
`default_nettype none
module ios_stretcher #(
  parameter int unsigned STRETCH_CYCLES = ios_pkg::STRETCH_CYCLES_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  ios_stretch_if.strt s_if
);
  localparam int unsigned CW = $clog2(STRETCH_CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(STRETCH_CYCLES);
  logic [CW-1:0] cnt_q;

  // counter reloads while raw is high so each occurrence gets the full tail
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !s_if.enable) begin
      cnt_q <= '0;
    end else if (s_if.raw) begin
      cnt_q <= LOAD;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CW'(1);
    end
  end

  assign s_if.shaped = s_if.enable ? (s_if.raw || cnt_q != '0) : s_if.raw;
endmodule // ios_stretcher
`default_nettype wire

// file: tb/ios_indicator_select_tb.sv
// Purpose: self-checking bench for the third indicator output select block
// Assumes: zero wait state slave; events reach the pin 4 edges after they change
// Notes: the driver queues expected values, a monitor compares reads in the data phase and the pin on the pin_chk edge
`timescale 1ns/100ps
`default_nettype none
module ios_indicator_select_tb;
  localparam int unsigned STRETCH = 10;
  localparam int unsigned MAX_CYC = 20000;
  localparam logic [31:0] A = ios_pkg::ISEL_ADDR;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [31:0] hrdata;
  logic hresp;
  logic pin;
  logic [5:0] ev = 6'h0;
  logic [5:0] e;
  logic [15:0] cfg;
  logic rd_dp = 1'b0;
  logic pin_dp = 1'b0;
  logic [31:0] exp_q[$];
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;

  always #25 i_sys_clk = ~i_sys_clk;

  ios_indicator_select #(.STRETCH_CYCLES(STRETCH)) dut_u (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp),
    .i_tx_activity(ev[4]), .i_rx_activity(ev[2]), .i_rx_addr_match(ev[5]),
    .i_rx_polarity_ok(ev[3]), .i_jabber(ev[1]), .i_collision(ev[0]),
    .o_third_indicator_pin(pin));

  // bit 5 only masks receive activity when no address match is seen
  function automatic logic raw_of(input logic [15:0] c, input logic [5:0] v);
    logic [4:0] g;
    g = v[4:0] & c[4:0];
    if (c[5] && !v[5]) g[2] = 1'b0;
    return |g;
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // on a read, d is the expected word rather than write data
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= ios_pkg::HSIZE_WORD;
    @(posedge i_sys_clk);
    while (hready !== 1'b1) @(posedge i_sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    if (!wr) begin
      exp_q.push_back(d);
      rd_dp <= 1'b1;
    end
    @(posedge i_sys_clk);
    while (hready !== 1'b1) @(posedge i_sys_clk);
    rd_dp <= 1'b0;
  endtask

  task automatic pin_chk(input logic v);
    exp_q.push_back({31'h0, v});
    pin_dp <= 1'b1;
    @(posedge i_sys_clk);
    pin_dp <= 1'b0;
  endtask

  always @(posedge i_sys_clk) begin
    if ((rd_dp === 1'b1 && hready === 1'b1) || pin_dp === 1'b1) begin
      n_checks++;
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("[ERR] %0t result with nothing expected", $time);
      end else if ((rd_dp ? {hrdata, hresp} : {31'h0, pin, 1'b0}) !== {exp_q[0], 1'b0}) begin
        bad_count++;
        $display("[ERR] %0t got %h pin %b exp %h", $time, hrdata, pin, exp_q[0]);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end

  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == MAX_CYC) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(69));
    repeat (12) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    xfer(1'b0, A, {16'h0, ios_pkg::ISEL_RESET});
    xfer(1'b1, A, 32'hFFFF_FFFF);
    xfer(1'b0, A, {16'h0, ios_pkg::ISEL_WMASK});
    xfer(1'b0, 32'h0000_0004, 32'h0);
    for (int i = 0; i < 40; i++) begin
      cfg = 16'($urandom) & 16'h003F;
      e = 6'($urandom);
      ev <= e;
      xfer(1'b1, A, {16'h0, cfg});
      repeat (5) @(posedge i_sys_clk);
      xfer(1'b0, A, {16'h0, raw_of(cfg, e), 7'h0, cfg[7:0]});
      pin_chk(raw_of(cfg, e));
    end
    ev <= 6'h0;
    xfer(1'b1, A, 32'h0000_0090);
    repeat (5) @(posedge i_sys_clk);
    ev <= 6'h10;
    @(posedge i_sys_clk);
    ev <= 6'h00;
    repeat (8) @(posedge i_sys_clk);
    pin_chk(1'b1);
    xfer(1'b0, A, 32'h0000_0090);
    repeat (10) @(posedge i_sys_clk);
    pin_chk(1'b0);
    ev <= 6'h10;
    @(posedge i_sys_clk);
    ev <= 6'h00;
    repeat (6) @(posedge i_sys_clk);
    xfer(1'b1, A, 32'h0000_0010);
    repeat (2) @(posedge i_sys_clk);
    pin_chk(1'b0);
    xfer(1'b1, A, 32'h0000_003F);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    pin_chk(1'b0);
    @(posedge i_sys_clk);
    xfer(1'b0, A, {16'h0, ios_pkg::ISEL_RESET});
    repeat (2) @(posedge i_sys_clk);
    if (exp_q.size() != 0) begin
      bad_count++;
      $display("[ERR] %0t expected results never seen", $time);
    end
    give_verdict();
  end
endmodule // ios_indicator_select_tb
`default_nettype wire
